/* File: design/ems_egress_select.v */
// Purpose: Egress mirror candidate selection: port mask, address filter, divider.
// Assumes: Frame strobes come from logic on the same clock.
// Notes: Decision appears one cycle after the frame strobe.
`include "ems_consts.vh"

module ems_egress_select (
    input wire clk_sys_in,            // Core clock
    input wire sys_rst_in,            // Sync reset, active high
    input wire frame_valid_in,        // Candidate frame strobe
    input wire [3:0] port_in,         // Egress port number
    input wire [47:0] da_in,          // Destination address
    input wire [47:0] sa_in,          // Source address
    input wire [1:0] filt_sel_in,     // Filter code
    input wire [8:0] mask_in,         // Port mask
    input wire div_en_in,             // Divider enable
    input wire [9:0] div_val_in,      // Divider field
    input wire div_clr_in,            // Divider rewritten
    input wire [47:0] cmp_addr_in,    // Egress compare address
    output reg copy_out,              // Mirror this frame, pulse
    output reg [9:0] count_out        // Filtered frame count
);

    reg port_hit;
    reg filt_hit;
    wire cand;
    wire wrap;

    always @* begin
        if (port_in <= `EMS_PORT_MAX) begin
            port_hit = mask_in[port_in];
        end else if (port_in == `EMS_PORT_MGMT) begin
            port_hit = mask_in[8];
        end else begin
            port_hit = 1'b0;
        end
    end

    always @* begin
        case (filt_sel_in)
            `EMS_FILT_ALL: filt_hit = 1'b1;
            `EMS_FILT_DA: filt_hit = (da_in == cmp_addr_in);
            `EMS_FILT_SA: filt_hit = (sa_in == cmp_addr_in);
            default: filt_hit = 1'b0; // Reserved code mirrors nothing
        endcase
    end

    // Filter only judges frames that are offered and masked in
    assign cand = frame_valid_in & port_hit & filt_hit;
    assign wrap = (count_out == div_val_in);

    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            copy_out <= 1'b0;
            count_out <= 10'h000;
        end else begin
            if (!div_en_in) begin
                copy_out <= cand;
            end else begin
                copy_out <= cand & wrap;
            end
            // Clear beats a same-cycle frame so the new ratio starts clean
            if (!div_en_in || div_clr_in) begin
                count_out <= 10'h000;
            end else if (cand) begin
                count_out <= wrap ? 10'h000 : count_out + 10'h001;
            end
        end
    end

endmodule

/* File: design/ems_top.v */
// Purpose: Mirror selection registers and egress/ingress mirror decisions.
// Assumes: Plain register port, 16-bit data, even byte addresses.
// Notes: Read data valid only in the cycle after the read strobe.
//
// Decided for this implementation: the address-and-strobe port.
`include "ems_consts.vh"

module ems_top #(
    parameter [31:0] PART_ID = `EMS_PART_ID_DEF // Arbitrary value
) (
    input wire clk_sys_in,                 // Core clock, 250 MHz
    input wire sys_rst_in,                 // Sync reset, active high
    input wire [7:0] reg_addr_in,          // Register byte address
    input wire [15:0] reg_wdata_in,        // Write data
    input wire reg_wr_in,                  // Write strobe
    input wire reg_rd_in,                  // Read strobe
    output reg [15:0] reg_rdata_out,       // Read data
    input wire egr_valid_in,               // Egress candidate strobe
    input wire [3:0] egr_port_in,          // Egress port number
    input wire [47:0] egr_da_in,           // Egress destination address
    input wire [47:0] egr_sa_in,           // Egress source address
    output wire egr_copy_out,              // Copy frame to capture port
    input wire ing_valid_in,               // Ingress frame strobe
    input wire [1:0] ing_filt_sel_in,      // Ingress filter code
    input wire [47:0] ing_da_in,           // Ingress destination address
    input wire [47:0] ing_sa_in,           // Ingress source address
    output reg ing_match_out,              // Ingress filter passed
    output reg [47:0] ing_cmp_addr_out     // Ingress compare address
);

    reg [15:0] ctrl_ff;
    reg [9:0] div_ff;
    reg [15:0] total_ff;
    reg [15:0] nxt_rdata;
    reg ing_hit;
    reg div_clr_ff;
    wire [47:0] ing_addr;
    wire [47:0] egr_addr;
    wire wr_ctrl;
    wire wr_div;
    wire [1:0] filt_sel;
    wire div_en;
    wire [8:0] mask;
    wire [9:0] div_count;
    wire copy;

    assign wr_ctrl = reg_wr_in & (reg_addr_in == `EMS_OFF_EGR_CTRL);
    assign wr_div = reg_wr_in & (reg_addr_in == `EMS_OFF_EGR_DIV);

    assign filt_sel = ctrl_ff[`EMS_FILT_HI:`EMS_FILT_LO];
    assign div_en = ctrl_ff[`EMS_DIV_EN_BIT];
    assign mask = ctrl_ff[`EMS_MASK_HI:`EMS_MASK_LO];

    // Control keeps reserved bits 12:9 as plain storage
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ctrl_ff <= `EMS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= reg_wdata_in;
        end
    end

    // Bits 15:10 of the divider are not stored
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            div_ff <= `EMS_DIV_RST;
        end else if (wr_div) begin
            div_ff <= reg_wdata_in[`EMS_DIV_HI:`EMS_DIV_LO];
        end
    end

    // Delayed so the count restarts one cycle after the new divider value is loaded
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            div_clr_ff <= 1'b0;
        end else begin
            div_clr_ff <= wr_div;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_half
            localparam [31:0] ING_OFF = `EMS_OFF_ING_ADDR0 + `EMS_HALF_STEP * gi;
            localparam [31:0] EGR_OFF = `EMS_OFF_EGR_ADDR0 + `EMS_HALF_STEP * gi;
            reg [15:0] ing_half_ff;
            reg [15:0] egr_half_ff;

            always @(posedge clk_sys_in) begin
                if (sys_rst_in) begin
                    ing_half_ff <= `EMS_HALF_RST;
                end else if (reg_wr_in && reg_addr_in == ING_OFF[7:0]) begin
                    ing_half_ff <= reg_wdata_in;
                end
            end

            always @(posedge clk_sys_in) begin
                if (sys_rst_in) begin
                    egr_half_ff <= `EMS_HALF_RST;
                end else if (reg_wr_in && reg_addr_in == EGR_OFF[7:0]) begin
                    egr_half_ff <= reg_wdata_in;
                end
            end

            assign ing_addr[16 * gi +: 16] = ing_half_ff;
            assign egr_addr[16 * gi +: 16] = egr_half_ff;
        end
    endgenerate

    // Identifier has no storage, so writes to it fall through unused
    always @* begin
        nxt_rdata = 16'h0000;
        case (reg_addr_in)
            `EMS_OFF_ING_ADDR0: begin
                nxt_rdata = ing_addr[15:0];
            end
            `EMS_OFF_ING_ADDR0 + 8'h02: begin
                nxt_rdata = ing_addr[31:16];
            end
            `EMS_OFF_ING_ADDR0 + 8'h04: begin
                nxt_rdata = ing_addr[47:32];
            end
            `EMS_OFF_EGR_CTRL: begin
                nxt_rdata = ctrl_ff;
            end
            `EMS_OFF_EGR_DIV: begin
                nxt_rdata = {6'h00, div_ff};
            end
            `EMS_OFF_EGR_ADDR0: begin
                nxt_rdata = egr_addr[15:0];
            end
            `EMS_OFF_EGR_ADDR0 + 8'h02: begin
                nxt_rdata = egr_addr[31:16];
            end
            `EMS_OFF_EGR_ADDR0 + 8'h04: begin
                nxt_rdata = egr_addr[47:32];
            end
            `EMS_OFF_PART_ID_LO: begin
                nxt_rdata = PART_ID[15:0];
            end
            `EMS_OFF_PART_ID_HI: begin
                nxt_rdata = PART_ID[31:16];
            end
            `EMS_OFF_EGR_STAT: begin
                nxt_rdata = {6'h00, div_count};
            end
            `EMS_OFF_EGR_TOTAL: begin
                nxt_rdata = total_ff;
            end
            default: begin
                nxt_rdata = 16'h0000;
            end
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= nxt_rdata;
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

    ems_egress_select u_egress_select (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .frame_valid_in(egr_valid_in),
        .port_in(egr_port_in),
        .da_in(egr_da_in),
        .sa_in(egr_sa_in),
        .filt_sel_in(filt_sel),
        .mask_in(mask),
        .div_en_in(div_en),
        .div_val_in(div_ff),
        .div_clr_in(div_clr_ff),
        .cmp_addr_in(egr_addr),
        .copy_out(copy),
        .count_out(div_count)
    );

    assign egr_copy_out = copy;

    // Wraps silently; software samples differences
    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            total_ff <= `EMS_TOTAL_RST;
        end else if (copy) begin
            total_ff <= total_ff + 16'h0001;
        end
    end

    always @* begin
        case (ing_filt_sel_in)
            `EMS_FILT_ALL: begin
                ing_hit = 1'b1;
            end
            `EMS_FILT_DA: begin
                ing_hit = (ing_da_in == ing_addr);
            end
            `EMS_FILT_SA: begin
                ing_hit = (ing_sa_in == ing_addr);
            end
            default: begin
                ing_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ing_match_out <= 1'b0;
            ing_cmp_addr_out <= 48'h0000_0000_0000;
        end else begin
            ing_match_out <= ing_valid_in & ing_hit;
            ing_cmp_addr_out <= ing_addr;
        end
    end

endmodule

/* File: pkg/ems_consts.vh */
// Purpose: Shared constants for the egress mirror select block.
// Assumes: 16-bit register port, byte addresses, halfword-aligned registers.
// Notes: 48-bit registers take three halfwords, lowest address holds bits 15:0.
`ifndef EMS_CONSTS_VH
`define EMS_CONSTS_VH

`define EMS_ADDR_W 8
`define EMS_DATA_W 16

`define EMS_OFF_ING_ADDR0 8'h16
`define EMS_OFF_EGR_CTRL 8'h1C
`define EMS_OFF_EGR_DIV 8'h1E
`define EMS_OFF_EGR_ADDR0 8'h20
`define EMS_OFF_PART_ID_LO 8'h30
`define EMS_OFF_PART_ID_HI 8'h32
`define EMS_OFF_EGR_STAT 8'h3C
`define EMS_OFF_EGR_TOTAL 8'h3E
`define EMS_HALF_STEP 8'h02

`define EMS_FILT_HI 15
`define EMS_FILT_LO 14
`define EMS_DIV_EN_BIT 13
`define EMS_MASK_HI 8
`define EMS_MASK_LO 0
`define EMS_DIV_HI 9
`define EMS_DIV_LO 0

`define EMS_FILT_ALL 2'b00
`define EMS_FILT_DA 2'b01
`define EMS_FILT_SA 2'b10

`define EMS_PORT_MAX 4'h5
`define EMS_PORT_MGMT 4'h8

`define EMS_CTRL_RST 16'h0000
`define EMS_DIV_RST 10'h000
`define EMS_HALF_RST 16'h0000
`define EMS_TOTAL_RST 16'h0000
`define EMS_PART_ID_DEF 32'hA5C3_0E01 // Arbitrary value

`endif

/* File: tb/ems_top_props.sv */
// Purpose: Port-level checks of the mirror select block.
// Assumes: One clock, sync reset high.
// Notes: Only sees ems_top ports.
`include "ems_consts.vh"
module ems_props #(
    parameter [31:0] PART_ID = 32'h0000_0000 // Arbitrary value
) (
    input wire clk_sys_in, // Clock
    input wire sys_rst_in, // Reset
    input wire [7:0] reg_addr_in, // Address
    input wire reg_rd_in, // Read strobe
    input wire [15:0] reg_rdata_out, // Read data
    input wire egr_valid_in, // Egress strobe
    input wire [3:0] egr_port_in, // Egress port
    input wire egr_copy_out, // Copy decision
    input wire ing_valid_in, // Ingress strobe
    input wire [1:0] ing_filt_sel_in, // Ingress code
    input wire [47:0] ing_sa_in, // Ingress SA
    input wire ing_match_out, // Ingress pass
    input wire [47:0] ing_cmp_addr_out // Ingress address
);
timeunit 1ns;
timeprecision 100ps;
default clocking cb @(posedge clk_sys_in); endclocking
default disable iff (sys_rst_in);
property p_rd_idle; !reg_rd_in |=> reg_rdata_out == 16'h0000; endproperty
a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
property p_id; reg_rd_in && reg_addr_in == `EMS_OFF_PART_ID_LO |=> reg_rdata_out == PART_ID[15:0]; endproperty
a_id: assert property (p_id) else $error("identifier low half wrong");
property p_div_hi; reg_rd_in && reg_addr_in == `EMS_OFF_EGR_DIV |=> reg_rdata_out[15:10] == 6'h00; endproperty
a_div_hi: assert property (p_div_hi) else $error("divider upper bits set");
property p_copy_cause; egr_copy_out |-> $past(egr_valid_in); endproperty
a_copy_cause: assert property (p_copy_cause) else $error("copy without frame");
property p_bad_port;
    egr_valid_in && egr_port_in > `EMS_PORT_MAX && egr_port_in != `EMS_PORT_MGMT |=> !egr_copy_out;
endproperty
a_bad_port: assert property (p_bad_port) else $error("unmapped port copied");
property p_ing_cause; !ing_valid_in |=> !ing_match_out; endproperty
a_ing_cause: assert property (p_ing_cause) else $error("ingress pass without frame");
property p_ing_sa;
    ing_valid_in && ing_filt_sel_in == 2'b10 |=> ing_match_out == ($past(ing_sa_in) == ing_cmp_addr_out);
endproperty
a_ing_sa: assert property (p_ing_sa) else $error("ingress source match wrong");
property p_ing_res; ing_valid_in && ing_filt_sel_in == 2'b11 |=> !ing_match_out; endproperty
a_ing_res: assert property (p_ing_res) else $error("reserved code passed");
endmodule
bind ems_top ems_props #(.PART_ID(PART_ID)) props_u (.clk_sys_in, .sys_rst_in, .reg_addr_in, .reg_rd_in,
    .reg_rdata_out, .egr_valid_in, .egr_port_in, .egr_copy_out, .ing_valid_in, .ing_filt_sel_in,
    .ing_sa_in, .ing_match_out, .ing_cmp_addr_out);

/* File: tb/testbench.sv */
// Purpose: Directed register and mirror decision tests.
// Assumes: One-cycle answers on every port.
// Notes: Shorter waits would hide latency slips.
`include "ems_consts.vh"
module testbench;
timeunit 1ns;
timeprecision 100ps;
localparam [31:0] PID = 32'h5A3C_71E2; // Arbitrary value
localparam [47:0] MA = 48'h0A1B_2C3D_4E5F;
localparam [47:0] MB = 48'h1122_3344_5566;
logic clk_sys_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, egr_valid_in = 0, ing_valid_in = 0;
logic [7:0] reg_addr_in = 0;
logic [15:0] reg_wdata_in = 0;
logic [3:0] egr_port_in = 0;
logic [1:0] ing_filt_sel_in = 0;
logic [47:0] egr_da_in = 0, egr_sa_in = 0, ing_da_in = 0, ing_sa_in = 0;
wire [15:0] reg_rdata_out;
wire [47:0] ing_cmp_addr_out;
wire egr_copy_out, ing_match_out;
int error_cnt = 0, comparisons = 0, tn = 0, i;
ems_top #(.PART_ID(PID)) dut_u (.clk_sys_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .egr_valid_in, .egr_port_in, .egr_da_in, .egr_sa_in, .egr_copy_out,
    .ing_valid_in, .ing_filt_sel_in, .ing_da_in, .ing_sa_in, .ing_match_out, .ing_cmp_addr_out);
initial forever #2 clk_sys_in = ~clk_sys_in;
task chk(input string n, input logic [47:0] e, input logic [47:0] g);
    comparisons++;
    if (g !== e) begin
        error_cnt++;
        $display("unexpected %s exp %h got %h", n, e, g);
    end
endtask
task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 0;
endtask
task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys_in);
    reg_rd_in <= 1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 0;
    #1 chk("rdata", {32'h0, e}, {32'h0, reg_rdata_out});
endtask
task w48(input logic [7:0] a, input logic [47:0] v);
    wr(a, v[15:0]);
    wr(a + 8'h02, v[31:16]);
    wr(a + 8'h04, v[47:32]);
endtask
task r48(input logic [7:0] a, input logic [47:0] v);
    rd(a, v[15:0]);
    rd(a + 8'h02, v[31:16]);
    rd(a + 8'h04, v[47:32]);
endtask
task ef(input logic [3:0] p, input logic [47:0] d, input logic [47:0] s, input logic e);
    @(posedge clk_sys_in);
    egr_valid_in <= 1;
    egr_port_in <= p;
    egr_da_in <= d;
    egr_sa_in <= s;
    @(posedge clk_sys_in);
    egr_valid_in <= 0;
    #1 chk("copy", {47'h0, e}, {47'h0, egr_copy_out});
endtask
task inf(input logic [1:0] c, input logic [47:0] d, input logic [47:0] s, input logic e);
    @(posedge clk_sys_in);
    ing_valid_in <= 1;
    ing_filt_sel_in <= c;
    ing_da_in <= d;
    ing_sa_in <= s;
    @(posedge clk_sys_in);
    ing_valid_in <= 0;
    #1 chk("match", {47'h0, e}, {47'h0, ing_match_out});
endtask
task tend;
    tn++;
    $display("test %0d done", tn);
endtask
task test_done;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
initial begin
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 0;
    r48(`EMS_OFF_ING_ADDR0, 48'h0);
    r48(`EMS_OFF_EGR_ADDR0, 48'h0);
    rd(`EMS_OFF_EGR_CTRL, 16'h0000);
    rd(`EMS_OFF_EGR_DIV, 16'h0000);
    tend;
    rd(`EMS_OFF_PART_ID_HI, PID[31:16]);
    wr(`EMS_OFF_PART_ID_LO, ~PID[15:0]);
    rd(`EMS_OFF_PART_ID_LO, PID[15:0]);
    wr(8'h40, 16'hFFFF);
    rd(8'h40, 16'h0000);
    tend;
    w48(`EMS_OFF_ING_ADDR0, MA);
    r48(`EMS_OFF_ING_ADDR0, MA);
    chk("ing_addr", MA, ing_cmp_addr_out);
    inf(2'b00, MB, MB, 1);
    inf(2'b01, MA, MB, 1);
    inf(2'b01, MB, MA, 0);
    inf(2'b10, MB, MA, 1);
    inf(2'b10, MA, MB, 0);
    inf(2'b11, MA, MA, 0);
    tend;
    w48(`EMS_OFF_EGR_ADDR0, MA);
    r48(`EMS_OFF_EGR_ADDR0, MA);
    wr(`EMS_OFF_EGR_CTRL, 16'h0101);
    ef(0, MB, MB, 1);
    ef(8, MB, MB, 1);
    ef(1, MB, MB, 0);
    ef(6, MB, MB, 0);
    wr(`EMS_OFF_EGR_CTRL, 16'h4101);
    ef(0, MA, MB, 1);
    ef(0, MB, MA, 0);
    ef(1, MA, MB, 0);
    wr(`EMS_OFF_EGR_CTRL, 16'h8101);
    ef(0, MB, MA, 1);
    ef(0, MA, MB, 0);
    wr(`EMS_OFF_EGR_CTRL, 16'hC101);
    rd(`EMS_OFF_EGR_CTRL, 16'hC101);
    ef(0, MA, MA, 0);
    tend;
    wr(`EMS_OFF_EGR_DIV, 16'hFFFF);
    rd(`EMS_OFF_EGR_DIV, 16'h03FF);
    wr(`EMS_OFF_EGR_DIV, 16'h0002);
    wr(`EMS_OFF_EGR_CTRL, 16'h2101);
    for (i = 1; i <= 6; i++) ef(0, MB, MB, i % 3 == 0);
    ef(0, MB, MB, 0);
    rd(`EMS_OFF_EGR_STAT, 16'h0001);
    wr(`EMS_OFF_EGR_DIV, 16'h0002);
    for (i = 1; i <= 3; i++) ef(0, MB, MB, i == 3);
    wr(`EMS_OFF_EGR_DIV, 16'h0000);
    for (i = 0; i < 3; i++) ef(0, MB, MB, 1);
    wr(`EMS_OFF_EGR_DIV, 16'h0002);
    wr(`EMS_OFF_EGR_CTRL, 16'h0101);
    for (i = 0; i < 3; i++) ef(0, MB, MB, 1);
    // Thirteen frames were mirrored above; the total is read-only
    wr(`EMS_OFF_EGR_TOTAL, 16'hFFFF);
    rd(`EMS_OFF_EGR_TOTAL, 16'h000D);
    tend;
    test_done;
end
endmodule
